// *** src/psc_pkg.sv ***
// constants, field layouts and carrier types of the per-port strap, address and link-mode block
// assumes one 25 MHz reference clock and an apb master for the register file
//
// Overview of operation
// R1 - port reset is the reset pin or-ed with control bit 15; indicators then go inactive
// R2 - base address from five pins; port n answers at base plus n
// R3 - system supplies a continuous 25 MHz reference clock timing all port logic
// R4 - three indicators per port, each showing a condition chosen by the led config register
// R5 - the same three indicator pins are read as that port's configuration inputs
// R6 - configuration pins sampled at power-up decide forced or automatic operation
// R7 - ports not forced resolve line conditions by auto-negotiation or parallel detection
// R8 - a negotiating port exchanges fast link pulse bursts with a capable partner
// R9 - without negotiation, link pulses select 10 Mbps, idle symbols select 100 Mbps
// R10 - half and full duplex at both rates, chosen per port
// R11 - a forced port runs its forced speed and duplex at once, no negotiation
// R12 - fiber is never chosen by negotiation, only by the register interface
// R13 - pin levels captured during reset; pins drive indicators only after release
package psc_pkg;

    localparam int NUM_PORTS = 6;
    localparam int NUM_LEDS  = 3;

    // apb map, byte addresses: port p register at p * stride + offset
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_LEDCFG  = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_BASE    = 8'h60;

    // control register fields
    localparam int CTRL_RESET   = 15;
    localparam int CTRL_SPEED   = 13;
    localparam int CTRL_AN_EN   = 12;
    localparam int CTRL_FIBER   = 10;
    localparam int CTRL_RESTART = 9;
    localparam int CTRL_DUPLEX  = 8;

    // strap pin positions within a port's three pins
    localparam int STRAP_AN     = 0;
    localparam int STRAP_SPEED  = 1;
    localparam int STRAP_DUPLEX = 2;

    // indicator condition codes, two bits per indicator in the led config register
    localparam logic [1:0] LED_LINK     = 2'h0;
    localparam logic [1:0] LED_SPEED    = 2'h1;
    localparam logic [1:0] LED_DUPLEX   = 2'h2;
    localparam logic [1:0] LED_ACTIVITY = 2'h3;
    localparam logic [5:0] LEDCFG_RESET = 6'h24;

    // cycles a software reset stays active, long enough for the pins to settle and sync
    localparam logic [2:0] SOFT_RST_CYCLES = 3'h4;

    typedef struct packed {
        logic flp;
        logic nlp;
        logic idle;
    } psc_line_t;

    typedef struct packed {
        logic an_en;
        logic speed100;
        logic full;
        logic fiber;
        logic restart;
    } psc_mode_t;

    typedef struct packed {
        logic link;
        logic speed100;
        logic full;
        logic fiber;
        logic negotiating;
        logic flp_tx;
    } psc_link_t;

    // address a port answers on; wraps modulo 32
    function automatic logic [4:0] port_addr(input logic [4:0] base, input logic [2:0] port);
        port_addr = base + {2'h0, port};
    endfunction

endpackage

// *** src/psc_port.sv ***
// one port's link-mode resolver: forced, fiber, negotiation or parallel detection
// assumes line detect inputs already synchronised to the reference clock
`timescale 1ns/1ps
module psc_port (
    // clock and port reset
    input  wire logic                clk,
    input  wire logic                rst,
    // configuration and line events
    input  wire psc_pkg::psc_mode_t  mode,
    input  wire psc_pkg::psc_line_t  line,
    // resolved link state
    output psc_pkg::psc_link_t       link
);
    typedef enum logic [1:0] {PS_HOLD, PS_DECIDE, PS_NEGOTIATE, PS_UP} psc_phase_t;

    typedef struct packed {
        psc_phase_t          phase;
        psc_pkg::psc_link_t  link;
    } psc_port_state_t;

    psc_port_state_t st;
    psc_port_state_t next_st;

    always_comb begin
        next_st = st;
        if (rst) begin
            next_st.phase = PS_HOLD;
            next_st.link  = '0;
        end else begin
            unique case (st.phase)
                PS_HOLD: begin
                    next_st.phase = PS_DECIDE;
                end
                PS_DECIDE: begin
                    next_st.link = '0;
                    if (mode.fiber) begin
                        // fiber only through the register path, always 100 Mbps
                        next_st.phase         = PS_UP;         // [R12]
                        next_st.link.fiber    = 1'b1;          // [R12]
                        next_st.link.speed100 = 1'b1;
                        next_st.link.full     = mode.full;     // [R10]
                    end else if (!mode.an_en) begin
                        next_st.phase         = PS_UP;         // [R6] [R11]
                        next_st.link.speed100 = mode.speed100; // [R11]
                        next_st.link.full     = mode.full;     // [R10] [R11]
                    end else begin
                        next_st.phase            = PS_NEGOTIATE; // [R7]
                        next_st.link.negotiating = 1'b1;
                        next_st.link.flp_tx      = 1'b1;         // [R8]
                    end
                end
                PS_NEGOTIATE: begin
                    // negotiated partner wins over parallel detection
                    if (line.flp) begin
                        next_st.phase         = PS_UP;     // [R8]
                        next_st.link.speed100 = 1'b1;
                        next_st.link.full     = 1'b1;
                    end else if (line.idle) begin
                        next_st.phase         = PS_UP;     // [R9]
                        next_st.link.speed100 = 1'b1;
                        next_st.link.full     = 1'b0;
                    end else if (line.nlp) begin
                        next_st.phase         = PS_UP;     // [R9]
                        next_st.link.speed100 = 1'b0;
                        next_st.link.full     = 1'b0;
                    end
                    if (next_st.phase == PS_UP) begin
                        next_st.link.link        = 1'b1;
                        next_st.link.negotiating = 1'b0;
                        next_st.link.flp_tx      = 1'b0;
                    end
                end
                PS_UP: begin
                    next_st.link.link = 1'b1;
                    if (mode.restart) begin
                        next_st.phase = PS_DECIDE;
                        next_st.link  = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign link = st.link;

endmodule // psc_port

// *** src/psc_strap_config.sv ***
// top of the strap, reset and address block for six ports, with an apb register file
// assumes address, indicator and line pins asynchronous to the reference clock; apb runs on the reference clock
`timescale 1ns/1ps
module psc_strap_config (
    // clock and reset
    input  wire logic                                   REF_CLK,
    input  wire logic                                   RESET,
    // apb slave
    input  wire logic                                   PSEL,
    input  wire logic                                   PENABLE,
    input  wire logic                                   PWRITE,
    input  wire logic [7:0]                             PADDR,
    input  wire logic [31:0]                            PWDATA,
    output logic      [31:0]                            PRDATA,
    output logic                                        PREADY,
    output logic                                        PSLVERR,
    // base address pins and derived per-port addresses
    input  wire logic [4:0]                             ADDR_PINS,
    output logic      [psc_pkg::NUM_PORTS-1:0][4:0]     PHY_ADDR,
    // indicator and configuration pins, open drain
    input  wire logic [psc_pkg::NUM_PORTS-1:0][2:0]     LED_IN,
    output logic      [psc_pkg::NUM_PORTS-1:0][2:0]     LED_OUT,
    output logic      [psc_pkg::NUM_PORTS-1:0][2:0]     LED_OE,
    // line events from the analog front end
    input  wire logic [psc_pkg::NUM_PORTS-1:0]          LINE_FLP_RX,
    input  wire logic [psc_pkg::NUM_PORTS-1:0]          LINE_NLP_RX,
    input  wire logic [psc_pkg::NUM_PORTS-1:0]          LINE_IDLE_RX,
    // resolved per-port state and reset
    output psc_pkg::psc_link_t [psc_pkg::NUM_PORTS-1:0] PORT_STATE,
    output logic      [psc_pkg::NUM_PORTS-1:0]          PORT_RESET
);
    localparam int NP = psc_pkg::NUM_PORTS;

    // all block state except the port resolvers', sync stages included, in one word registered on every rising edge of REF_CLK
    typedef struct packed {
        logic [NP-1:0][15:0]      ctrl;
        logic [NP-1:0][2:0]       soft_cnt;
        logic [NP-1:0][5:0]       ledcfg;
        logic [NP-1:0][2:0]       strap;
        logic [NP-1:0][4:0]       phy_addr;
        logic [NP-1:0][2:0]       led_oe;
        logic [1:0][4:0]          addr_sync;
        logic [1:0][NP-1:0][2:0]  led_sync;
        logic [1:0][NP-1:0][2:0]  line_sync;
        logic [31:0]              prdata;
        logic                     pslverr;
    } psc_top_state_t;

    psc_top_state_t                  st;
    psc_top_state_t                  next_st;
    logic [NP-1:0]                   port_rst;
    psc_pkg::psc_mode_t [NP-1:0]     mode;
    psc_pkg::psc_link_t [NP-1:0]     link;
    logic                            wr_go;
    logic                            setup_go;

    // register select: port index, register offset, mapped flag
    function automatic logic decode_ok(input logic [7:0] a);
        logic port_ok;
        port_ok   = a[7:4] < 4'(NP);
        decode_ok = (a == psc_pkg::OFF_BASE) ||
                    (port_ok && a[3:0] == psc_pkg::OFF_CTRL[3:0]) ||
                    (port_ok && a[3:0] == psc_pkg::OFF_LEDCFG[3:0]) ||
                    (port_ok && a[3:0] == psc_pkg::OFF_STATUS[3:0]);
    endfunction

    // true when address a selects register off of port p
    function automatic logic reg_hit(input logic [7:0] a, input int p, input logic [7:0] off);
        reg_hit = (a[7:4] == 4'(p)) && (a[3:0] == off[3:0]);
    endfunction

    function automatic logic cond_of(input logic [1:0] sel, input psc_pkg::psc_link_t l);
        unique case (sel)
            psc_pkg::LED_LINK:   cond_of = l.link;
            psc_pkg::LED_SPEED:  cond_of = l.speed100;
            psc_pkg::LED_DUPLEX: cond_of = l.full;
            default:             cond_of = l.negotiating;
        endcase
    endfunction

    // strap pins rewrite the mode bits; fiber never comes from the pins, only from a write
    function automatic logic [15:0] strap_ctrl(input logic [15:0] c, input logic [2:0] s);
        strap_ctrl                       = c;
        strap_ctrl[psc_pkg::CTRL_AN_EN]  = s[psc_pkg::STRAP_AN];     // [R6]
        strap_ctrl[psc_pkg::CTRL_SPEED]  = s[psc_pkg::STRAP_SPEED];
        strap_ctrl[psc_pkg::CTRL_DUPLEX] = s[psc_pkg::STRAP_DUPLEX]; // [R10]
        strap_ctrl[psc_pkg::CTRL_FIBER]  = 1'b0;                     // [R12]
    endfunction

    // access phase write to a writable register; status and base writes drop silently
    assign wr_go    = PSEL && PENABLE && PWRITE && decode_ok(PADDR) && (PADDR != psc_pkg::OFF_BASE);
    assign setup_go = PSEL && !PENABLE;

    // mode bits each port resolver sees, straight from its control register

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            port_rst[p]      = RESET | st.ctrl[p][psc_pkg::CTRL_RESET]; // [R1]
            mode[p].an_en    = st.ctrl[p][psc_pkg::CTRL_AN_EN];
            mode[p].speed100 = st.ctrl[p][psc_pkg::CTRL_SPEED];
            mode[p].full     = st.ctrl[p][psc_pkg::CTRL_DUPLEX];
            mode[p].fiber    = st.ctrl[p][psc_pkg::CTRL_FIBER];
            mode[p].restart  = st.ctrl[p][psc_pkg::CTRL_RESTART];
        end
    end

    always_comb begin
        next_st = st;
        // address, indicator and line pins pass two flops before any logic looks at them
        next_st.addr_sync = {st.addr_sync[0], ADDR_PINS};
        next_st.led_sync  = {st.led_sync[0], LED_IN};
        for (int p = 0; p < NP; p++) begin
            next_st.line_sync[1][p] = st.line_sync[0][p];
            next_st.line_sync[0][p] = {LINE_FLP_RX[p], LINE_NLP_RX[p], LINE_IDLE_RX[p]};
            next_st.phy_addr[p]     = psc_pkg::port_addr(st.addr_sync[1], 3'(p)); // [R2]
            // restart is a one-cycle command; soft reset counts down then clears
            next_st.ctrl[p][psc_pkg::CTRL_RESTART] = 1'b0;
            if (st.soft_cnt[p] != 3'h0) begin
                next_st.soft_cnt[p] = st.soft_cnt[p] - 3'h1;
            end else begin
                next_st.ctrl[p][psc_pkg::CTRL_RESET] = 1'b0;
            end
        end

        // apb write, taken in the access phase; zero wait states
        next_st.pslverr = 1'b0;
        if (wr_go) begin
            for (int p = 0; p < NP; p++) begin
                if (reg_hit(PADDR, p, psc_pkg::OFF_CTRL)) begin
                    next_st.ctrl[p] = PWDATA[15:0]; // [R12]
                    // a fresh reset write restarts the count from the top
                    if (PWDATA[psc_pkg::CTRL_RESET]) begin
                        next_st.soft_cnt[p] = psc_pkg::SOFT_RST_CYCLES - 3'h1;
                    end
                end
                if (reg_hit(PADDR, p, psc_pkg::OFF_LEDCFG)) begin
                    next_st.ledcfg[p] = PWDATA[5:0]; // [R4]
                end
            end
        end

        // read data and error prepared in the setup phase so they stand through access
        if (setup_go) begin
            // unmapped reads return zero with an error
            next_st.prdata  = 32'h0;
            next_st.pslverr = !decode_ok(PADDR);
            if (PADDR == psc_pkg::OFF_BASE) begin
                next_st.prdata = {27'h0, st.addr_sync[1]};
            end
            for (int p = 0; p < NP; p++) begin
                if (reg_hit(PADDR, p, psc_pkg::OFF_CTRL)) begin
                    next_st.prdata = {16'h0, st.ctrl[p]};
                end
                if (reg_hit(PADDR, p, psc_pkg::OFF_LEDCFG)) begin
                    next_st.prdata = {26'h0, st.ledcfg[p]};
                end
                if (reg_hit(PADDR, p, psc_pkg::OFF_STATUS)) begin
                    next_st.prdata = {19'h0,
                                      st.phy_addr[p],
                                      st.strap[p],
                                      link[p].negotiating,
                                      link[p].fiber,
                                      link[p].full,
                                      link[p].speed100,
                                      link[p].link};
                end
            end
        end else if (PSEL && PENABLE) begin
            next_st.pslverr = st.pslverr;
        end

        for (int p = 0; p < NP; p++) begin
            if (port_rst[p]) begin
                // pins are released in reset, so their straps can be read back
                next_st.led_oe[p] = 3'h0;                                                  // [R1] [R13]
                next_st.strap[p]  = st.led_sync[1][p];                                     // [R5] [R13]
                next_st.ctrl[p]   = strap_ctrl(next_st.ctrl[p], st.led_sync[1][p]);        // [R6] [R12]
            end else begin
                for (int k = 0; k < psc_pkg::NUM_LEDS; k++) begin
                    next_st.led_oe[p][k] = cond_of(st.ledcfg[p][2*k +: 2], link[p]);       // [R4]
                end
            end
        end

        // the reset pin also restores the register file; port state follows through port_rst
        if (RESET) begin
            next_st.ledcfg   = {NP{psc_pkg::LEDCFG_RESET}};
            next_st.soft_cnt = '0;
            next_st.prdata   = 32'h0;
            next_st.pslverr  = 1'b0;
            for (int p = 0; p < NP; p++) begin
                // bits with no reset meaning start clear rather than unknown
                next_st.ctrl[p] = strap_ctrl(16'h0, st.led_sync[1][p]); // [R1] [R13]
            end
        end
    end

    always_ff @(posedge REF_CLK) begin // [R3]
        st <= next_st;
    end

    // each resolver sits in its own port reset, so a soft reset leaves the others running
    for (genvar p = 0; p < NP; p++) begin : g_port
        psc_port u_port (
            .clk  (REF_CLK),
            .rst  (port_rst[p]),
            .mode (mode[p]),
            .line (st.line_sync[1][p]),
            .link (link[p])
        );
    end

    assign PRDATA     = st.prdata;
    // every register is a flop read out in the setup phase, so no wait states are needed
    assign PREADY     = 1'b1;
    assign PSLVERR    = st.pslverr & PSEL & PENABLE;
    assign PHY_ADDR   = st.phy_addr;
    // open drain: the pin is only pulled low, so the enable alone carries the indicator
    assign LED_OUT    = '0;
    assign LED_OE     = st.led_oe;
    assign PORT_STATE = link;
    assign PORT_RESET = port_rst;

endmodule // psc_strap_config

// *** test/psc_link_partner.sv ***
// remote link partner for six ports: drives line event levels
// assumes a capable partner answers only while the port sends bursts
`timescale 1ns/1ps
module psc_link_partner (
    // clock
    input  wire logic            clk,
    // per port: 0 silent, 1 bursts, 2 link pulses, 3 idle
    input  wire logic [5:0][1:0] mode,
    input  wire logic [5:0]      flp_tx,
    // line events
    output logic      [5:0]      flp,
    output logic      [5:0]      nlp,
    output logic      [5:0]      idle
);
    always_ff @(posedge clk) begin
        for (int p = 0; p < 6; p++) begin
            flp[p]  <= (mode[p] == 2'h1) && flp_tx[p];
            nlp[p]  <= mode[p] == 2'h2;
            idle[p] <= mode[p] == 2'h3;
        end
    end
endmodule // psc_link_partner

// *** test/psc_strap_config_asserts.sv ***
// port checks of the strap, address and link-mode block
// assumes port 0 strapped forced, port 1 bursts, port 3 link pulses
`timescale 1ns/1ps
module psc_strap_config_asserts (
    // clock and reset
    input  wire logic                                       REF_CLK,
    input  wire logic                                       RESET,
    // apb
    input  wire logic                                       PSEL,
    input  wire logic                                       PENABLE,
    input  wire logic                                       PSLVERR,
    // pins and state
    input  wire logic [4:0]                                 ADDR_PINS,
    input  wire logic [psc_pkg::NUM_PORTS-1:0][4:0]         PHY_ADDR,
    input  wire logic [psc_pkg::NUM_PORTS-1:0][2:0]         LED_IN,
    input  wire logic [psc_pkg::NUM_PORTS-1:0][2:0]         LED_OE,
    input  wire logic [psc_pkg::NUM_PORTS-1:0]              LINE_FLP_RX,
    input  wire logic [psc_pkg::NUM_PORTS-1:0]              LINE_NLP_RX,
    input  wire psc_pkg::psc_link_t [psc_pkg::NUM_PORTS-1:0] PORT_STATE,
    input  wire logic [psc_pkg::NUM_PORTS-1:0]              PORT_RESET
);
    // pins read back low once indicators drive, so keep what reset saw
    logic [psc_pkg::NUM_PORTS-1:0][2:0] straps;
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            straps <= LED_IN;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);
    port_reset_a: assert property (disable iff (1'b0) RESET |-> &PORT_RESET)
        else $error("port reset not held by reset pin");
    rst_quiet_a: assert property (disable iff (1'b0) PORT_RESET[2] [*3] |-> LED_OE[2] == 3'h0 && PORT_STATE[2] == '0)
        else $error("port active during its reset");
    addr_sum_a: assert property ($stable(ADDR_PINS) [*4] |-> PHY_ADDR[5] == ADDR_PINS + 5'h5)
        else $error("port address not base plus port");
    forced_mode_a: assert property ($fell(RESET) && !straps[0][0] |-> ##[1:6] (PORT_STATE[0].link
        && PORT_STATE[0].speed100 == straps[0][1] && PORT_STATE[0].full == straps[0][2] && !PORT_STATE[0].negotiating))
        else $error("forced port not up in strapped mode");
    auto_start_a: assert property ($fell(RESET) && straps[1][0] |-> ##[1:4] PORT_STATE[1].negotiating)
        else $error("automatic port did not negotiate");
    flp_tx_a: assert property (PORT_STATE[1].negotiating |-> PORT_STATE[1].flp_tx)
        else $error("negotiating without bursts");
    flp_full_a: assert property (PORT_STATE[1].negotiating && LINE_FLP_RX[1] |-> ##[1:5]
        (PORT_STATE[1].link && PORT_STATE[1].speed100 && PORT_STATE[1].full))
        else $error("negotiation did not end at full rate");
    pd_nlp_a: assert property (PORT_STATE[3].negotiating && LINE_NLP_RX[3] |-> ##[1:5]
        (PORT_STATE[3].link && !PORT_STATE[3].speed100 && !PORT_STATE[3].full))
        else $error("link pulses did not give low rate");
    fiber_mgmt_a: assert property ($rose(PORT_STATE[5].fiber) |-> !$past(PORT_STATE[5].negotiating))
        else $error("fiber chosen by negotiation");
    soft_len_a: assert property ($rose(PORT_RESET[2]) |-> PORT_RESET[2] [*4] ##1 !PORT_RESET[2])
        else $error("software reset length wrong");
    err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error outside access phase");
    cover property ($rose(PORT_RESET[2]));
    cover property ($rose(PORT_STATE[5].fiber));
    cover property ($fell(RESET) && straps[1][0]);
endmodule // psc_strap_config_asserts
bind psc_strap_config psc_strap_config_asserts u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PSLVERR(PSLVERR), .ADDR_PINS(ADDR_PINS), .PHY_ADDR(PHY_ADDR), .LED_IN(LED_IN),
    .LED_OE(LED_OE), .LINE_FLP_RX(LINE_FLP_RX), .LINE_NLP_RX(LINE_NLP_RX), .PORT_STATE(PORT_STATE),
    .PORT_RESET(PORT_RESET));

// *** test/psc_strap_config_tb.sv ***
// bench for the strap, address and link-mode block with a remote partner
// assumes pull resistors on the open-drain indicator pins set the straps
`timescale 1ns/1ps
module psc_strap_config_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [4:0]             addr_pins = 5'h1d;
    logic [5:0][4:0]        phy_addr;
    // port 0 forced 100 full, 2 forced 10 half, 5 forced 100 half, others automatic
    logic [5:0][2:0]        strap = {3'h2, 3'h1, 3'h1, 3'h0, 3'h1, 3'h6};
    logic [5:0][1:0]        pmode = {2'h0, 2'h3, 2'h2, 2'h0, 2'h1, 2'h0};
    logic [5:0][2:0]        led_in;
    logic [5:0][2:0]        led_oe;
    logic [5:0][2:0]        led_out;
    logic [5:0]             flp, nlp, idle, flp_tx, port_reset;
    psc_pkg::psc_link_t [5:0] st;
    logic [31:0]            rd;
    logic                   err;
    int                     failures = 0;
    int                     compares = 0;

    always #20 clk = ~clk;
    // a driven pin is pulled low, a released one sits at its strap level
    assign led_in = strap & ~led_oe;
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            flp_tx[p] = st[p].flp_tx;
        end
    end

    psc_strap_config dut (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ADDR_PINS(addr_pins), .PHY_ADDR(phy_addr), .LED_IN(led_in), .LED_OUT(led_out), .LED_OE(led_oe),
        .LINE_FLP_RX(flp), .LINE_NLP_RX(nlp), .LINE_IDLE_RX(idle), .PORT_STATE(st), .PORT_RESET(port_reset));
    psc_link_partner partner (.clk(clk), .mode(pmode), .flp_tx(flp_tx), .flp(flp), .nlp(nlp), .idle(idle));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task t_power_up;
        logic [5:0][3:0] exp;
        // {link, speed100, full, fiber} per port, port 5 first
        exp = {4'hc, 4'hc, 4'h8, 4'h8, 4'he, 4'he};
        repeat (5) @(posedge clk);
        chk(32'(port_reset), 32'h3f);
        chk(32'(led_oe), 32'h0);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        for (int p = 0; p < 6; p++) begin
            chk(32'({st[p].link, st[p].speed100, st[p].full, st[p].fiber}), 32'(exp[p]));
            chk(32'(led_oe[p]), 32'({exp[p][1], exp[p][2], exp[p][3]}));
            apb(1'b0, 8'(p * 16 + 8), 32'h0);
            chk(32'(rd[12:5]), 32'({5'(5'h1d + p), strap[p]}));
        end
        $display("power-up test done");
    endtask

    task t_addr;
        @(posedge clk);
        addr_pins <= 5'h02;
        repeat (5) @(posedge clk);
        #1;
        for (int p = 0; p < 6; p++) begin
            chk(32'(phy_addr[p]), 32'(p + 2));
        end
        // base register follows the pins; a write to it is dropped without error
        apb(1'b1, 8'h60, 32'h1f);
        chk(32'(err), 32'h0);
        apb(1'b0, 8'h60, 32'h0);
        chk(rd, 32'h2);
        $display("address test done");
    endtask

    task t_ledcfg;
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h24);
        apb(1'b1, 8'h04, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(led_oe[0]), 32'h7);
        // all three show negotiation, which a forced port never does
        apb(1'b1, 8'h04, 32'h3f);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h3f);
        chk(32'(led_oe[0]), 32'h0);
        chk(32'(led_out), 32'h0);
        $display("indicator test done");
    endtask

    task t_soft;
        pmode[2] <= 2'h2;
        apb(1'b1, 8'h20, 32'h9000);
        @(posedge clk);
        #1;
        chk(32'(port_reset), 32'h04);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(led_oe[2]), 32'h0);
        repeat (20) @(posedge clk);
        #1;
        chk(32'({st[2].link, st[2].speed100, st[2].full}), 32'h4);
        $display("software reset test done");
    endtask

    task t_fiber;
        apb(1'b1, 8'h50, 32'h2700);
        repeat (8) @(posedge clk);
        #1;
        chk(32'({st[5].link, st[5].speed100, st[5].full, st[5].fiber}), 32'hf);
        apb(1'b0, 8'h70, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        $display("fiber and unmapped test done");
    endtask

    initial begin
        t_power_up();
        t_addr();
        t_ledcfg();
        t_soft();
        t_fiber();
        conclude();
    end

    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule // psc_strap_config_tb
